// file: hw/spi_flash_consts.vh
// Constants of the serial flash core: command codes, status layout, geometry, register map.
// Included by the core; holds definitions only.
`ifndef SPI_FLASH_CONSTS_VH
`define SPI_FLASH_CONSTS_VH
`define CMD_NONE              8'h00
`define CMD_WRITE_LATCH_SET   8'h06
`define CMD_WRITE_LATCH_CLEAR 8'h04
`define CMD_PAGE_PROGRAM      8'h02
`define CMD_SECTOR_ERASE      8'h20
`define CMD_BLOCK_ERASE       8'hD8
`define CMD_CHIP_ERASE        8'hC7
`define CMD_STATUS_WRITE      8'h01
`define CMD_STATUS_READ       8'h05
`define CMD_DATA_READ         8'h03
`define CMD_DEEP_SLEEP        8'hB9
`define CMD_WAKE_IDENTIFY     8'hAB
`define CMD_OTP_ENTER         8'h3A
`define ST_SPROT              7
`define ST_PROT_HI            4
`define ST_PROT_LO            2
`define ERASED_BYTE           8'hFF
`define PAGE_BITS             8
`define SECTOR_BITS           12
`define BLOCK_BITS            16
`define OTP_BITS              9
`define PROT_BASE_SHIFT       15
`define PROT_ALL              3'h6
`define PROT_NONE             3'h0
`define BYTE_OPCODE           10'd0
`define BYTE_STATUS_DATA      10'd1
`define BYTE_ADDR_LAST        10'd3
`define BYTE_ID_FROM          10'd3
`define LEN_ONE_BYTE          10'd1
`define LEN_STATUS_WRITE      10'd2
`define LEN_ERASE             10'd4
`define LEN_PROGRAM_MIN       10'd5
`define BYTE_CNT_MAX          10'h3FF
`define REG_STATUS_ADR        8'h00
`define REG_EXTEND_ADR        8'h04
`define EXTEND_RESET          16'h0000
`endif

// file: hw/spi_flash_core.v
// Serial flash core: SPI slave front end, command decoder, program/erase engine, status
// register and a Wishbone classic register window. Assumes the SPI master drives clock
// and select far slower than i_core_clk (at least eight core clocks per SPI half period).
`timescale 1ns/1ps
`include "spi_flash_consts.vh"
module spi_flash_core #(
  parameter       ADDR_W    = 21,
  parameter [7:0] DEVICE_ID = 8'h5A // Arbitrary value.
) (
  input  wire        i_core_clk,
  input  wire        i_nrst,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [31:0] i_wb_dat,
  input  wire [3:0]  i_wb_sel,
  output reg         o_wb_ack,
  output reg  [31:0] o_wb_dat,
  input  wire        i_spi_clk,
  input  wire        i_spi_cs_n,
  input  wire        i_serial_in,
  input  wire        i_wp_n,
  output reg         o_serial_out,
  output reg         o_serial_out_oe,
  output reg         o_active,
  output reg         o_deep_sleep
);
  localparam [1:0] ENG_IDLE  = 2'd0;
  localparam [1:0] ENG_PROG  = 2'd1;
  localparam [1:0] ENG_ERASE = 2'd2;
  localparam [1:0] ENG_HOLD  = 2'd3;
  localparam [ADDR_W:0]   LEN_UNIT = 1;
  localparam [ADDR_W-1:0] ONES     = {ADDR_W{1'b1}};

  reg [7:0] mem     [0:(1<<ADDR_W)-1];
  reg [7:0] otp_mem [0:(1<<`OTP_BITS)-1];
  reg [7:0] page_buf [0:(1<<`PAGE_BITS)-1];

  // Nonvolatile bits: no reset term, so they keep their value across i_nrst.
  reg [2:0]  protect_size_reg  = `PROT_NONE;
  reg        status_protect_reg = 1'b0;
  reg        otp_lock_reg      = 1'b0;

  reg [2:0]  clk_sync_reg;
  reg [2:0]  cs_sync_reg;
  reg [1:0]  din_sync_reg;
  reg [1:0]  wp_sync_reg;
  reg        write_permission_latch_reg;
  reg        deep_sleep_reg;
  reg        otp_mode_reg;
  reg [2:0]  bit_cnt_reg;
  reg [9:0]  byte_cnt_reg;
  reg [6:0]  rx_sh_reg;
  reg [7:0]  opcode_reg;
  reg [23:0] addr_reg;
  reg [7:0]  wsr_data_reg;
  reg [7:0]  tx_sh_reg;
  reg [7:0]  pidx_reg;
  reg [255:0] pvalid_reg;
  reg        go_reg;
  reg [1:0]  go_op_reg;
  reg        go_otp_reg;
  reg [ADDR_W-1:0] go_base_reg;
  reg [ADDR_W:0]   go_len_reg;
  reg [1:0]  eng_state_reg;
  reg [ADDR_W:0] eng_cnt_reg;
  reg [15:0] ext_cnt_reg;
  reg        done_reg;
  reg [15:0] extend_reg;

  wire sck_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  wire sck_fall = ~clk_sync_reg[1] & clk_sync_reg[2];
  wire cs_rise  = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire cs_fall  = ~cs_sync_reg[1] & cs_sync_reg[2];
  wire selected = ~cs_sync_reg[1];
  wire din      = din_sync_reg[1];
  wire busy     = go_reg | (eng_state_reg != ENG_IDLE);
  wire hw_prot  = status_protect_reg & ~wp_sync_reg[1];
  wire [7:0] rx_byte  = {rx_sh_reg, din};
  wire       byte_done = sck_rise & selected & (bit_cnt_reg == 3'h7);
  wire [7:0] eff_op = (deep_sleep_reg && opcode_reg != `CMD_WAKE_IDENTIFY) ?
                      `CMD_NONE : opcode_reg;
  wire [7:0] status_byte = {otp_mode_reg ? otp_lock_reg : status_protect_reg,
                            2'b00, protect_size_reg, write_permission_latch_reg, busy};
  wire [23:0] rd_addr = (byte_cnt_reg <= `BYTE_ADDR_LAST) ? {addr_reg[15:0], rx_byte} :
                        addr_reg + 24'h1;
  wire [7:0] rd_byte = otp_mode_reg ? otp_mem[rd_addr[`OTP_BITS-1:0]] :
                       mem[rd_addr[ADDR_W-1:0]];
  wire [ADDR_W-1:0] eng_addr = go_base_reg + eng_cnt_reg[ADDR_W-1:0];

  function prot_hit;
    input [ADDR_W-1:0] a;
    input [2:0]        bp;
    begin
      if (bp == `PROT_NONE)
        prot_hit = 1'b0;
      else if (bp >= `PROT_ALL)
        prot_hit = 1'b1;
      else
        prot_hit = (a >> (`PROT_BASE_SHIFT + bp)) == (ONES >> (`PROT_BASE_SHIFT + bp));
    end
  endfunction

  // The second stage of each synchroniser feeds logic; the clock and select edge detectors also use the third.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_sync_reg <= 3'h0;
      cs_sync_reg  <= 3'h7;
      din_sync_reg <= 2'h0;
      wp_sync_reg  <= 2'h3;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], i_spi_clk};
      cs_sync_reg  <= {cs_sync_reg[1:0], i_spi_cs_n};
      din_sync_reg <= {din_sync_reg[0], i_serial_in};
      wp_sync_reg  <= {wp_sync_reg[0], i_wp_n};
    end
  end

  // Frame parser and command execution. All but the read commands run at deselect so that short or
  // misaligned frames can be discarded whole.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      write_permission_latch_reg <= 1'b0;
      deep_sleep_reg  <= 1'b0;
      otp_mode_reg    <= 1'b0;
      bit_cnt_reg     <= 3'h0;
      byte_cnt_reg    <= 10'h000;
      rx_sh_reg       <= 7'h00;
      opcode_reg      <= `CMD_NONE;
      addr_reg        <= 24'h000000;
      wsr_data_reg    <= 8'h00;
      tx_sh_reg       <= 8'h00;
      pidx_reg        <= 8'h00;
      pvalid_reg      <= {256{1'b0}};
      go_reg          <= 1'b0;
      go_op_reg       <= ENG_IDLE;
      go_otp_reg      <= 1'b0;
      go_base_reg     <= {ADDR_W{1'b0}};
      go_len_reg      <= {(ADDR_W+1){1'b0}};
      o_serial_out    <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else begin
      go_reg          <= 1'b0;
      o_serial_out_oe <= selected;
      if (done_reg) begin
        write_permission_latch_reg <= 1'b0;
        pvalid_reg <= {256{1'b0}};
      end
      if (cs_fall) begin
        bit_cnt_reg  <= 3'h0;
        byte_cnt_reg <= `BYTE_OPCODE;
        tx_sh_reg    <= 8'h00;
        if (!busy)
          pvalid_reg <= {256{1'b0}};
      end
      if (sck_rise && selected) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        rx_sh_reg   <= rx_byte[6:0];
      end
      if (sck_fall && selected) begin
        o_serial_out <= tx_sh_reg[7];
        tx_sh_reg    <= {tx_sh_reg[6:0], 1'b0};
      end
      if (byte_done) begin
        if (byte_cnt_reg != `BYTE_CNT_MAX)
          byte_cnt_reg <= byte_cnt_reg + 10'd1;
        tx_sh_reg <= 8'h00;
        if (byte_cnt_reg == `BYTE_OPCODE) begin
          opcode_reg <= rx_byte;
          if (rx_byte == `CMD_STATUS_READ && !deep_sleep_reg)
            tx_sh_reg <= status_byte;
        end else begin
          if (byte_cnt_reg <= `BYTE_ADDR_LAST || eff_op == `CMD_DATA_READ)
            addr_reg <= rd_addr;
          if (byte_cnt_reg == `BYTE_ADDR_LAST)
            pidx_reg <= rx_byte;
          if (byte_cnt_reg == `BYTE_STATUS_DATA)
            wsr_data_reg <= rx_byte;
          case (eff_op)
            `CMD_STATUS_READ:   tx_sh_reg <= status_byte;
            `CMD_DATA_READ:     if (byte_cnt_reg >= `BYTE_ADDR_LAST) tx_sh_reg <= rd_byte;
            `CMD_WAKE_IDENTIFY: if (byte_cnt_reg >= `BYTE_ID_FROM) tx_sh_reg <= DEVICE_ID;
            `CMD_PAGE_PROGRAM: begin
              // Data wraps inside the page; later bytes overwrite earlier ones.
              if (byte_cnt_reg > `BYTE_ADDR_LAST && !busy) begin
                pvalid_reg[pidx_reg] <= 1'b1;
                pidx_reg <= pidx_reg + 8'h1;
              end
            end
            default: tx_sh_reg <= 8'h00;
          endcase
        end
      end
      if (cs_rise && bit_cnt_reg == 3'h0) begin
        go_otp_reg <= otp_mode_reg;
        case (eff_op)
          `CMD_WAKE_IDENTIFY:
            if (byte_cnt_reg >= `LEN_ONE_BYTE) deep_sleep_reg <= 1'b0;
          `CMD_WRITE_LATCH_SET:
            if (byte_cnt_reg == `LEN_ONE_BYTE && !busy) write_permission_latch_reg <= 1'b1;
          `CMD_WRITE_LATCH_CLEAR:
            if (byte_cnt_reg == `LEN_ONE_BYTE && !busy) begin
              write_permission_latch_reg <= 1'b0;
              otp_mode_reg <= 1'b0;
            end
          `CMD_OTP_ENTER:
            if (byte_cnt_reg == `LEN_ONE_BYTE && !busy) otp_mode_reg <= 1'b1;
          `CMD_DEEP_SLEEP:
            if (byte_cnt_reg == `LEN_ONE_BYTE && !busy) deep_sleep_reg <= 1'b1;
          `CMD_STATUS_WRITE:
            if (byte_cnt_reg == `LEN_STATUS_WRITE && write_permission_latch_reg && !busy &&
                (otp_mode_reg || !hw_prot)) begin
              go_reg    <= 1'b1;
              go_op_reg <= ENG_HOLD;
            end
          `CMD_PAGE_PROGRAM:
            if (byte_cnt_reg >= `LEN_PROGRAM_MIN && write_permission_latch_reg && !busy &&
                !(otp_mode_reg ? otp_lock_reg :
                  prot_hit(addr_reg[ADDR_W-1:0], protect_size_reg))) begin
              go_reg      <= 1'b1;
              go_op_reg   <= ENG_PROG;
              go_base_reg <= addr_reg[ADDR_W-1:0] & (ONES << `PAGE_BITS);
              go_len_reg  <= LEN_UNIT << `PAGE_BITS;
            end
          `CMD_SECTOR_ERASE, `CMD_BLOCK_ERASE:
            if (byte_cnt_reg == `LEN_ERASE && write_permission_latch_reg && !busy &&
                !(otp_mode_reg ? otp_lock_reg :
                  prot_hit(addr_reg[ADDR_W-1:0], protect_size_reg))) begin
              go_reg    <= 1'b1;
              go_op_reg <= ENG_ERASE;
              if (otp_mode_reg) begin
                go_base_reg <= {ADDR_W{1'b0}};
                go_len_reg  <= LEN_UNIT << `OTP_BITS;
              end else if (eff_op == `CMD_SECTOR_ERASE) begin
                go_base_reg <= addr_reg[ADDR_W-1:0] & (ONES << `SECTOR_BITS);
                go_len_reg  <= LEN_UNIT << `SECTOR_BITS;
              end else begin
                go_base_reg <= addr_reg[ADDR_W-1:0] & (ONES << `BLOCK_BITS);
                go_len_reg  <= LEN_UNIT << `BLOCK_BITS;
              end
            end
          `CMD_CHIP_ERASE:
            if (byte_cnt_reg == `LEN_ONE_BYTE && write_permission_latch_reg && !busy &&
                !otp_mode_reg && protect_size_reg == `PROT_NONE) begin
              go_reg      <= 1'b1;
              go_op_reg   <= ENG_ERASE;
              go_base_reg <= {ADDR_W{1'b0}};
              go_len_reg  <= LEN_UNIT << ADDR_W;
            end
          default: go_reg <= 1'b0;
        endcase
      end
    end
  end

  // Internal write cycle. The extend register adds software-chosen busy time to every cycle.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      eng_state_reg <= ENG_IDLE;
      eng_cnt_reg   <= {(ADDR_W+1){1'b0}};
      ext_cnt_reg   <= `EXTEND_RESET;
      done_reg      <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (eng_state_reg)
        ENG_IDLE: begin
          eng_cnt_reg <= {(ADDR_W+1){1'b0}};
          ext_cnt_reg <= extend_reg;
          if (go_reg)
            eng_state_reg <= go_op_reg;
        end
        ENG_PROG, ENG_ERASE: begin
          eng_cnt_reg <= eng_cnt_reg + LEN_UNIT;
          if (eng_cnt_reg == go_len_reg - LEN_UNIT)
            eng_state_reg <= ENG_HOLD;
        end
        ENG_HOLD: begin
          if (ext_cnt_reg == 16'h0000) begin
            eng_state_reg <= ENG_IDLE;
            done_reg      <= 1'b1;
          end else
            ext_cnt_reg <= ext_cnt_reg - 16'h0001;
        end
        default: eng_state_reg <= ENG_IDLE;
      endcase
    end
  end

  always @(posedge i_core_clk) begin
    if (byte_done && eff_op == `CMD_PAGE_PROGRAM && byte_cnt_reg > `BYTE_ADDR_LAST && !busy)
      page_buf[pidx_reg] <= rx_byte;
    if (eng_state_reg == ENG_PROG && pvalid_reg[eng_cnt_reg[`PAGE_BITS-1:0]]) begin
      if (go_otp_reg)
        otp_mem[eng_addr[`OTP_BITS-1:0]] <= otp_mem[eng_addr[`OTP_BITS-1:0]] &
                                            page_buf[eng_cnt_reg[`PAGE_BITS-1:0]];
      else
        mem[eng_addr] <= mem[eng_addr] & page_buf[eng_cnt_reg[`PAGE_BITS-1:0]];
    end
    if (eng_state_reg == ENG_ERASE) begin
      if (go_otp_reg)
        otp_mem[eng_addr[`OTP_BITS-1:0]] <= `ERASED_BYTE;
      else
        mem[eng_addr] <= `ERASED_BYTE;
    end
    if (done_reg && go_op_reg == ENG_HOLD) begin
      if (go_otp_reg)
        otp_lock_reg <= 1'b1;
      else begin
        status_protect_reg <= wsr_data_reg[`ST_SPROT];
        protect_size_reg   <= wsr_data_reg[`ST_PROT_HI:`ST_PROT_LO];
      end
    end
  end

  // Wishbone classic slave: one wait state, unmapped addresses read zero.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb_ack     <= 1'b0;
      o_wb_dat     <= 32'h00000000;
      extend_reg   <= `EXTEND_RESET;
      o_active     <= 1'b0;
      o_deep_sleep <= 1'b0;
    end else begin
      // The deselect edge itself counts as active, so a starting cycle leaves no gap.
      o_active     <= selected | busy | cs_rise;
      o_deep_sleep <= deep_sleep_reg;
      o_wb_ack     <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
      o_wb_dat     <= 32'h00000000;
      if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
        if (i_wb_adr == `REG_STATUS_ADR)
          o_wb_dat <= {21'h000000, o_active, otp_mode_reg, deep_sleep_reg, status_byte};
        if (i_wb_adr == `REG_EXTEND_ADR)
          o_wb_dat <= {16'h0000, extend_reg};
      end
      // Writes land on the edge at which the master sees ack, as classic cycles expect.
      if (i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_adr == `REG_EXTEND_ADR) begin
        if (i_wb_sel[0])
          extend_reg[7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1])
          extend_reg[15:8] <= i_wb_dat[15:8];
      end
    end
  end
endmodule // spi_flash_core

// file: sim/spi_flash_core_assertions.sv
// Port checker for the serial flash core.
// Assumes it is bound to spi_flash_core and sees only that module's ports.
`timescale 1ns/1ps
module spi_flash_core_assertions (
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0]  i_wb_sel,
  input wire logic        o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic        i_spi_clk,
  input wire logic        i_spi_cs_n,
  input wire logic        i_serial_in,
  input wire logic        i_wp_n,
  input wire logic        o_serial_out,
  input wire logic        o_serial_out_oe,
  input wire logic        o_active,
  input wire logic        o_deep_sleep
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  a_ack_after_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered in one cycle");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack cycle");
  a_oe_on_select: assert property ($fell(i_spi_cs_n) |-> ##[1:5] o_serial_out_oe)
    else $error("output not enabled after select");
  a_active_on_select: assert property (!i_spi_cs_n [*5] |-> o_active)
    else $error("not active while selected");
  a_out_falling_only: assert property ($changed(o_serial_out) |-> !i_spi_clk || i_spi_cs_n)
    else $error("serial output moved while link clock high");
  a_sleep_kept_sel: assert property (o_deep_sleep && !i_spi_cs_n |=> o_deep_sleep)
    else $error("left power-down inside a frame");
  a_sleep_entry_desel: assert property ($rose(o_deep_sleep) |-> i_spi_cs_n)
    else $error("power-down entered while selected");
  a_standby_deselect: assert property ($fell(o_active) |-> i_spi_cs_n && $past(i_spi_cs_n, 2))
    else $error("standby entered while selected");
  c_sleep: cover property ($rose(o_deep_sleep));
  c_standby: cover property ($fell(o_active));
  c_wb_write: cover property (o_wb_ack && i_wb_we);
endmodule // spi_flash_core_assertions
bind spi_flash_core spi_flash_core_assertions u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
  .i_spi_clk(i_spi_clk), .i_spi_cs_n(i_spi_cs_n), .i_serial_in(i_serial_in), .i_wp_n(i_wp_n),
  .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe), .o_active(o_active),
  .o_deep_sleep(o_deep_sleep));

// file: sim/spi_master_model.sv
// SPI bus master model: sends txq as one frame and collects rxq.
// Assumes the core clock paces it; a link half period is eight core clocks.
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic i_core_clk,
  input  wire logic i_miso,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // The clock takes its idle level before each frame and toggles only inside it; that level picks the mode.
  task run(input logic cpol);
    logic [7:0] r;
    rxq = {};
    o_sclk <= cpol;
    repeat (8) @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    foreach (txq[i]) begin
      for (int b = 7; b >= 0; b--) begin
        repeat (8) @(posedge i_core_clk);
        o_sclk <= 1'b0;
        o_mosi <= txq[i][b];
        repeat (8) @(posedge i_core_clk);
        o_sclk <= 1'b1;
        r[b] = i_miso;
      end
      rxq.push_back(r);
    end
    repeat (8) @(posedge i_core_clk);
    o_sclk <= cpol;
    repeat (8) @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    // A released data line must not keep showing its last bit.
    o_mosi <= ~o_mosi;
    repeat (8) @(posedge i_core_clk);
  endtask
endmodule // spi_master_model

// file: sim/spi_flash_operating_core_tb.sv
// Testbench for the serial flash core with a byte-level model of array and status.
// Assumes the default array size and a 200 MHz core clock.
`timescale 1ns/1ps
`include "spi_flash_consts.vh"
module spi_flash_operating_core_tb;
  localparam logic [7:0] DEV_ID = 8'hA5; // Arbitrary value.
  logic        clk, nrst, cyc, stb, we, ack, sclk, cs_n, mosi, wp_n, miso, act, slp, oe;
  logic [7:0]  adr, st, rx;
  logic [31:0] wdat, rdat, q, e;
  logic [3:0]  sel;
  logic [7:0]  mem_m[int];
  logic [7:0]  dq[$];
  logic [2:0]  bp_m;
  logic        srp_m, wel_m;
  int          failures, checked, cyc_cnt;
  spi_flash_core #(.DEVICE_ID(DEV_ID)) dut (.i_core_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_spi_clk(sclk), .i_spi_cs_n(cs_n), .i_serial_in(mosi),
    .i_wp_n(wp_n), .o_serial_out(miso), .o_serial_out_oe(oe), .o_active(act),
    .o_deep_sleep(slp));
  spi_master_model u_m (.i_core_clk(clk), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_mosi(mosi));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task test_done();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 100000) begin
      failures++;
      test_done();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    r = rdat;
    chk("wishbone latency", n, 2);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  function logic [7:0] stx();
    return {srp_m, 2'b00, bp_m, wel_m, 1'b0};
  endfunction
  function bit prot(input int a);
    if (bp_m == 3'h0) return 1'b0;
    if (bp_m >= 3'h6) return 1'b1;
    return a >= 32'h200000 - (32'h10000 << (bp_m - 3'h1));
  endfunction
  task send(input logic [7:0] b[$]);
    u_m.txq = b;
    u_m.run(1'($urandom % 2));
  endtask
  task fill(input int n);
    dq = {};
    repeat (n) dq.push_back(8'($urandom));
  endtask
  task rs();
    send('{`CMD_STATUS_READ, 8'hFF});
    st = u_m.rxq[1];
  endtask
  task idle();
    int n;
    n = 0;
    do begin
      rs();
      n++;
    end while (st[0] !== 1'b0 && n < 100);
    chk("busy cleared", st[0], 1'b0);
    chk("standby after cycle", act, 1'b0);
    chk("output released", oe, 1'b0);
  endtask
  task pw(input logic [7:0] c[$]);
    send('{`CMD_WRITE_LATCH_SET});
    send(c);
    idle();
  endtask
  task prog(input int a);
    int p;
    fill(2);
    pw({`CMD_PAGE_PROGRAM, 8'(a >> 16), 8'(a >> 8), 8'(a), dq});
    foreach (dq[i]) begin
      p = (a & ~255) | ((a + i) & 255);
      if (!prot(a)) mem_m[p] = mem_m[p] & dq[i];
    end
    wel_m = prot(a);
  endtask
  task erase(input int a);
    send('{`CMD_WRITE_LATCH_SET});
    send('{`CMD_SECTOR_ERASE, 8'(a >> 16), 8'(a >> 8), 8'(a)});
    chk("active after deselect", act, 1'b1);
    rs();
    chk("busy in erase", st[0], 1'b1);
    for (int i = 0; i < 4096; i++) mem_m[a + i] = 8'hFF;
    wel_m = 1'b0;
    idle();
  endtask
  task rd(input int a, input int n);
    dq = '{`CMD_DATA_READ, 8'(a >> 16), 8'(a >> 8), 8'(a)};
    repeat (n) dq.push_back(8'hFF);
    send(dq);
    for (int i = 0; i < n; i++) chk("array byte", u_m.rxq[4 + i], mem_m[a + i]);
  endtask
  initial begin
    {nrst, cyc, stb, we, adr, wdat, sel, bp_m, srp_m, wel_m} = '0;
    wp_n = 1'b1;
    void'($urandom(89));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, `REG_STATUS_ADR, 32'h0, q);
    chk("status reset", q, 32'h0);
    wb(1'b0, `REG_EXTEND_ADR, 32'h0, q);
    chk("extend reset", q, 32'h0);
    e = 32'($urandom % 8);
    wb(1'b1, `REG_EXTEND_ADR, e, q);
    wb(1'b1, `REG_STATUS_ADR, 32'hFF, q);
    wb(1'b0, `REG_EXTEND_ADR, 32'h0, q);
    chk("extend", q, e);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("test registers done");
    send('{`CMD_WRITE_LATCH_SET});
    wel_m = 1'b1;
    rs();
    chk("latch set", st, stx());
    send('{`CMD_WRITE_LATCH_CLEAR});
    wel_m = 1'b0;
    rs();
    chk("latch clear", st, stx());
    erase(32'h000000);
    rd(32'h000FFE, 2);
    prog(32'h0000FF);
    prog(32'h0000FF);
    rd(32'h000000, 1);
    rd(32'h0000FF, 1);
    send('{`CMD_SECTOR_ERASE, 8'h00, 8'h00, 8'h00});
    rd(32'h000000, 1);
    $display("test program and erase done");
    erase(32'h1F0000);
    erase(32'h0FF000);
    for (int c = 0; c < 8; c++) begin
      pw('{`CMD_STATUS_WRITE, {3'b000, 3'(c), 2'b00}});
      bp_m = 3'(c);
      wel_m = 1'b0;
      rs();
      chk("protect code", st, stx());
      prog(32'h1F0000);
      prog(32'h0FFFFF);
      rd(32'h1F0000, 1);
      rd(32'h0FFFFF, 1);
    end
    send('{`CMD_WRITE_LATCH_SET});
    wel_m = 1'b1;
    send('{`CMD_CHIP_ERASE});
    send('{`CMD_BLOCK_ERASE, 8'h1F, 8'h00, 8'h00});
    rs();
    chk("protected erase", st, stx());
    rd(32'h1F0000, 1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    wel_m = 1'b0;
    rs();
    chk("protect over reset", st, stx());
    pw('{`CMD_STATUS_WRITE, 8'h80});
    {srp_m, bp_m} = {1'b1, 3'h0};
    wp_n <= 1'b0;
    pw('{`CMD_STATUS_WRITE, 8'h1C});
    send('{`CMD_WRITE_LATCH_CLEAR});
    rs();
    chk("frozen status", st, stx());
    wp_n <= 1'b1;
    pw('{`CMD_STATUS_WRITE, 8'h00});
    srp_m = 1'b0;
    $display("test protection done");
    send('{`CMD_DEEP_SLEEP});
    chk("asleep", slp, 1'b1);
    send('{`CMD_WRITE_LATCH_SET});
    wb(1'b0, `REG_STATUS_ADR, 32'h0, q);
    chk("sleep flag", q[8], 1'b1);
    send('{`CMD_WAKE_IDENTIFY, 8'h00, 8'h00, 8'h00, 8'hFF});
    chk("identity", u_m.rxq[4], DEV_ID);
    chk("awake", slp, 1'b0);
    rs();
    chk("latch after sleep", st, stx());
    send('{`CMD_OTP_ENTER});
    pw('{`CMD_SECTOR_ERASE, 8'h00, 8'h00, 8'h00});
    fill(1);
    rx = dq[0];
    pw({`CMD_PAGE_PROGRAM, 8'h00, 8'h00, 8'h00, dq});
    pw('{`CMD_STATUS_WRITE, 8'h00});
    rs();
    chk("lock set", st[7], 1'b1);
    pw('{`CMD_PAGE_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h00});
    pw('{`CMD_STATUS_WRITE, 8'h00});
    send('{`CMD_DATA_READ, 8'h00, 8'h00, 8'h00, 8'hFF});
    chk("locked byte", u_m.rxq[4], rx);
    rs();
    chk("lock kept", st[7], 1'b1);
    send('{`CMD_WRITE_LATCH_CLEAR});
    wb(1'b0, `REG_STATUS_ADR, 32'h0, q);
    chk("otp left", q[9], 1'b0);
    $display("test sleep and otp done");
    test_done();
  end
endmodule // spi_flash_operating_core_tb
